// ==== pkg/nfc_defines.vh ====
/*
  constants for the nor flash host controller: command codes, unlock
  addresses, geometry and bus timings in ns, us and ms for a 50 mhz sys_clk.
  assumes it is included by bare name from rtl files only.
*/
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

`define NFC_CLK_NS        20
// unlock address / data pairs of the write protection sequence
`define NFC_UNLOCK_ADDR1  20'h05555
`define NFC_UNLOCK_ADDR2  20'h02aaa
`define NFC_UNLOCK_DATA1  16'h00aa
`define NFC_UNLOCK_DATA2  16'h0055
`define NFC_SETUP_PROGRAM 16'h00a0
`define NFC_SETUP_ERASE   16'h0080
`define NFC_CODE_SECTOR   16'h0030
`define NFC_CODE_BLOCK    16'h0050
`define NFC_CODE_CHIP     16'h0010
`define NFC_CHIP_ADDR     20'h05555
// sector and block address start lines
`define NFC_SECTOR_LSB    11
`define NFC_BLOCK_LSB     15
// operation codes on the user port
`define NFC_OP_READ       3'h0
`define NFC_OP_PROGRAM    3'h1
`define NFC_OP_SECTOR     3'h2
`define NFC_OP_BLOCK      3'h3
`define NFC_OP_CHIP       3'h4
// status bit positions
`define NFC_POLL_BIT      7
`define NFC_TOGGLE_BIT    6
// strobe timing in ns and busy timeouts in us and ms, turned into cycles in the module
`define NFC_STROBE_NS     60
`define NFC_SETUP_NS      20
`define NFC_PROGRAM_US    20
`define NFC_ERASE_MS      100
`endif

// ==== rtl/nfc_host.v ====
/*
  host side controller for a parallel x16 nor flash: issues reads, word
  programs and sector/block/chip erases through chip select, output gate
  and write strobe, then polls the toggle status bit until completion.
  assumes inputs synchronous to sys_clk; the bench resolves the data wire
  from data_oe and models the flash.
*/
// Function
// - write strobe low while chip select low
// - host sends three unlock writes, then word
// - busy reads only carry two status bits
// - host erases sector before programming word; the code leaves that erase to the caller
// - sector erase: six writes, last code 30
// - block erase: six writes, last code 50
// - chip erase: six writes, code 10 fixed address
// - on mismatch reread twice before completion
`timescale 1ns/1ps
`include "nfc_defines.vh"

module nfc_host #(
  parameter AW          = 20,                 // address width
  parameter DW          = 16,                 // data width
  parameter PROG_CYCLES = (`NFC_PROGRAM_US * 1000) / `NFC_CLK_NS,
  parameter ERASE_CYCLES = (`NFC_ERASE_MS * 1000000) / `NFC_CLK_NS // erase timeout
)(
  input  wire          sys_clk,      // system clock 50 mhz
  input  wire          rstn,         // async reset, active low
  input  wire          req_valid,    // operation request
  output wire          req_ready,    // controller idle
  input  wire [2:0]    req_op,       // operation code
  input  wire [AW-1:0] req_addr,     // word, sector or block address
  input  wire [DW-1:0] req_data,     // program data
  output reg           done,         // one-cycle completion pulse
  output reg           fail,         // with done: timeout
  output reg  [DW-1:0] rd_data,      // read data
  output reg  [AW-1:0] addr_lines,   // flash address lines
  output reg  [DW-1:0] data_out,     // data_lines driven value
  output reg           data_oe,      // data_lines output enable
  input  wire [DW-1:0] data_in,      // data_lines sampled value
  output reg           chip_sel_n,   // chip select, active low
  output reg           out_gate_n,   // output gate, active low
  output reg           wr_strobe_n   // write strobe, active low
);
  localparam STB = (`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS;
  localparam SU  = (`NFC_SETUP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS;
  localparam S_IDLE = 3'd0, S_WSU = 3'd1, S_WLO = 3'd2, S_WHI = 3'd3;
  localparam S_RLO = 3'd4, S_RHI = 3'd5, S_DONE = 3'd6;

  reg [2:0]    state;
  reg [2:0]    op;
  reg [2:0]    step;       // index of write cycle in the sequence
  reg [2:0]    nwrites;    // writes in this sequence
  reg [AW-1:0] taddr;
  reg [DW-1:0] tdata;
  reg [7:0]    tcnt;       // strobe phase timer
  reg [31:0]   wait_cnt;   // busy timeout counter
  reg          polling;
  reg          have_prev;
  reg [DW-1:0] prev;
  reg [1:0]    rereads;    // stable rereads after a settled toggle

  assign req_ready = (state == S_IDLE);

  // address of each write cycle of the command sequences
  function [AW-1:0] seq_addr;
    input [2:0] s;
    input [2:0] o;
    input [AW-1:0] a;
    begin
      case (s)
        3'd0, 3'd2, 3'd3: seq_addr = `NFC_UNLOCK_ADDR1;
        3'd1, 3'd4:       seq_addr = `NFC_UNLOCK_ADDR2;
        default:
          if (o == `NFC_OP_CHIP)
            seq_addr = `NFC_CHIP_ADDR;
          else if (o == `NFC_OP_SECTOR)
            seq_addr = {a[AW-1:`NFC_SECTOR_LSB], {`NFC_SECTOR_LSB{1'b0}}};
          else
            seq_addr = {a[AW-1:`NFC_BLOCK_LSB], {`NFC_BLOCK_LSB{1'b0}}};
      endcase
      if (o == `NFC_OP_PROGRAM && s == 3'd3)
        seq_addr = a;
    end
  endfunction

  // data of each write cycle
  function [DW-1:0] seq_data;
    input [2:0] s;
    input [2:0] o;
    input [DW-1:0] d;
    begin
      case (s)
        3'd0, 3'd3: seq_data = `NFC_UNLOCK_DATA1;
        3'd1, 3'd4: seq_data = `NFC_UNLOCK_DATA2;
        3'd2: seq_data = (o == `NFC_OP_PROGRAM) ? `NFC_SETUP_PROGRAM
                                              : `NFC_SETUP_ERASE;
        default:
          case (o)
            `NFC_OP_SECTOR: seq_data = `NFC_CODE_SECTOR;
            `NFC_OP_BLOCK:  seq_data = `NFC_CODE_BLOCK;
            default:        seq_data = `NFC_CODE_CHIP;
          endcase
      endcase
      if (o == `NFC_OP_PROGRAM && s == 3'd3)
        seq_data = d;
    end
  endfunction

  // main sequencer; chip select is held low across the whole write strobe
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= S_IDLE; op <= 3'h0; step <= 3'h0; nwrites <= 3'h0;
      taddr <= {AW{1'b0}}; tdata <= {DW{1'b0}}; tcnt <= 8'h00;
      wait_cnt <= 32'h0; polling <= 1'b0; have_prev <= 1'b0;
      prev <= {DW{1'b0}}; rereads <= 2'h0; done <= 1'b0; fail <= 1'b0;
      rd_data <= {DW{1'b0}}; addr_lines <= {AW{1'b0}};
      data_out <= {DW{1'b0}}; data_oe <= 1'b0;
      chip_sel_n <= 1'b1; out_gate_n <= 1'b1; wr_strobe_n <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      tcnt <= tcnt + 8'h01;
      case (state)
        S_IDLE:
        begin
          chip_sel_n <= 1'b1;  // deselected keeps device in standby
          out_gate_n <= 1'b1;
          data_oe <= 1'b0;
          if (req_valid)
          begin
            op <= req_op; taddr <= req_addr; tdata <= req_data;
            step <= 3'h0; tcnt <= 8'h00; fail <= 1'b0;
            polling <= 1'b0; have_prev <= 1'b0; rereads <= 2'h0;
            wait_cnt <= 32'h0;
            // programming only clears bits, so the caller erases first
            nwrites <= (req_op == `NFC_OP_PROGRAM) ? 3'd4 : 3'd6;
            if (req_op == `NFC_OP_READ)
            begin
              addr_lines <= req_addr;
              chip_sel_n <= 1'b0;
              out_gate_n <= 1'b0;     // device drives only when both low
              state <= S_RLO;
            end
            else
              state <= S_WSU;
          end
        end
        S_WSU:
        begin
          // present address, data and select in the same cycle, before strobing
          addr_lines <= seq_addr(step, op, taddr);
          data_out <= seq_data(step, op, tdata);
          data_oe <= 1'b1;
          chip_sel_n <= 1'b0;
          if (tcnt >= SU[7:0])
          begin
            wr_strobe_n <= 1'b0;      // strobe low inside select
            tcnt <= 8'h00;
            state <= S_WLO;
          end
        end
        S_WLO:
          if (tcnt >= STB[7:0])
          begin
            // strobe rises first so data is latched before select lifts
            wr_strobe_n <= 1'b1;
            tcnt <= 8'h00;
            state <= S_WHI;
          end
        S_WHI:
          if (tcnt >= SU[7:0])
          begin
            chip_sel_n <= 1'b1;
            data_oe <= 1'b0;
            tcnt <= 8'h00;
            if (step == nwrites - 3'd1)
            begin
              polling <= 1'b1;        // status valid after last rise
              addr_lines <= (op == `NFC_OP_PROGRAM) ? taddr : seq_addr(step, op, taddr);
              state <= S_RLO;
            end
            else
            begin
              step <= step + 3'd1;
              state <= S_WSU;
            end
          end
        S_RLO:
        begin
          chip_sel_n <= 1'b0;
          out_gate_n <= 1'b0;
          if (polling)
            wait_cnt <= wait_cnt + 32'h1;
          if (tcnt >= STB[7:0])
          begin
            chip_sel_n <= 1'b1;       // each read is a separate cycle
            out_gate_n <= 1'b1;
            tcnt <= 8'h00;
            rd_data <= data_in;
            state <= polling ? S_RHI : S_DONE;
          end
        end
        S_RHI:
        begin
          wait_cnt <= wait_cnt + 32'h1;
          if (tcnt >= SU[7:0])
          begin
            tcnt <= 8'h00;
            have_prev <= 1'b1;
            prev <= rd_data;
            // toggle bit settled: confirm with one more read
            if (have_prev && prev[`NFC_TOGGLE_BIT] == rd_data[`NFC_TOGGLE_BIT])
              rereads <= rereads + 2'h1;
            else
              rereads <= 2'h0;        // still busy
            if (have_prev && prev[`NFC_TOGGLE_BIT] == rd_data[`NFC_TOGGLE_BIT]
                && rereads == 2'h1)
              state <= S_DONE;
            else if (wait_cnt >= ((op == `NFC_OP_PROGRAM) ? PROG_CYCLES : ERASE_CYCLES))
            begin
              fail <= 1'b1;           // bounded busy time exceeded
              state <= S_DONE;
            end
            else
              state <= S_RLO;
          end
        end
        S_DONE:
        begin
          done <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // nfc_host

// ==== verification/nfc_host_properties.sv ====
/*
  concurrent checks on the flash pins of the nor flash host controller.
  assumes a bind onto nfc_host and its four-cycle strobe and six-cycle read.
*/
`timescale 1ns/1ps
module nfc_host_properties #(
  parameter AW = 20,
  parameter DW = 16
)(
  input wire          sys_clk,      // system clock
  input wire          rstn,         // async reset, active low
  input wire          req_valid,    // operation request
  input wire          req_ready,    // controller idle
  input wire          done,         // completion pulse
  input wire          data_oe,      // host drives data lines
  input wire [2:0]    req_op,       // operation code
  input wire [AW-1:0] addr_lines,   // flash address
  input wire [DW-1:0] data_out,     // driven data
  input wire          chip_sel_n,   // chip select, active low
  input wire          out_gate_n,   // output gate, active low
  input wire          wr_strobe_n   // write strobe, active low
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire        take = req_valid && req_ready;
  logic [2:0] op_q;
  logic [3:0] polls;
  // count status reads since the last write strobe; saturates so it never wraps
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      op_q  <= 3'h0;
      polls <= 4'h0;
    end
    else
    begin
      if (take)
        op_q <= req_op;
      if (!wr_strobe_n)
        polls <= 4'h0;
      else if ($fell(out_gate_n) && polls != 4'hf)
        polls <= polls + 4'h1;
    end
  strobe_in_select_a: assert property (!wr_strobe_n |-> !chip_sel_n && out_gate_n)
    else $error("write strobe outside a selected write");
  strobe_width_a: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n[*4] ##1 wr_strobe_n)
    else $error("write strobe width wrong");
  write_drives_a: assert property (!wr_strobe_n |-> data_oe)
    else $error("data not driven during write");
  write_stable_a: assert property (!wr_strobe_n |=> wr_strobe_n ||
    ($stable(addr_lines) && $stable(data_out))) else $error("bus moved in write");
  no_fight_a: assert property (!out_gate_n |-> !data_oe)
    else $error("host drives while flash outputs");
  idle_quiet_a: assert property (req_ready |-> chip_sel_n && wr_strobe_n && !data_oe)
    else $error("pins active while idle");
  read_answer_a: assert property (take && req_op == 3'h0 |-> ##6 done)
    else $error("read not done in six cycles");
  unlock_first_a: assert property (take && req_op != 3'h0 |-> ##[1:4]
    (!wr_strobe_n && addr_lines == 20'h05555 && data_out == 16'h00aa)) else $error("bad unlock");
  reread_twice_a: assert property (done && op_q != 3'h0 |-> polls >= 4'h3)
    else $error("completion without two rereads");
endmodule // nfc_host_properties
bind nfc_host nfc_host_properties #(.AW(AW), .DW(DW)) u_props (.sys_clk(sys_clk), .rstn(rstn),
  .req_valid(req_valid), .req_ready(req_ready), .done(done), .data_oe(data_oe),
  .req_op(req_op), .addr_lines(addr_lines), .data_out(data_out), .chip_sel_n(chip_sel_n),
  .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n));

// ==== verification/nfc_flash_model.sv ====
/*
  behavioural x16 nor flash standing opposite the host controller.
  assumes the bench resolves the data wire from both enables.
*/
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter PROG_NS  = 3000,
  parameter ERASE_NS = 9000
)(
  input  wire [19:0] addr_lines,   // address
  input  wire [15:0] dq_in,        // resolved data wire
  input  wire        chip_sel_n,   // chip select, active low
  input  wire        out_gate_n,   // output gate, active low
  input  wire        wr_strobe_n,  // write strobe, active low
  output wire [15:0] dq_out,       // read value
  output wire        dq_oe         // flash drives
);
  logic [15:0] mem [0:1048575];
  logic [19:0] la;
  logic [15:0] pd;
  int          step = 0;
  bit          busy = 0, ers = 0, tog = 0;
  wire         we = !chip_sel_n && !wr_strobe_n;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // outputs only while selected and gated; busy reads give status only
  assign dq_oe  = !chip_sel_n && !out_gate_n;
  assign dq_out = busy ? {8'h00, ~ers & ~pd[7], tog, 6'h00} : mem[addr_lines];
  always @(posedge dq_oe) if (busy) tog = ~tog;
  // address on the later falling strobe, data on the first rising one
  always @(posedge we) la = addr_lines;
  always @(negedge we) if (!busy) accept(la, dq_in);
  // any write off the expected pattern drops back to read mode at once
  task automatic accept(input [19:0] a, input [15:0] d);
    case (step)
      0, 3: step = (a == 20'h05555 && d == 16'h00aa) ? step + 1 : 0;
      1, 4: step = (a == 20'h02aaa && d == 16'h0055) ? step + 1 : 0;
      2: step = (a != 20'h05555) ? 0 : (d == 16'h00a0) ? 6 : (d == 16'h0080) ? 3 : 0;
      6:
      begin
        step = 0;
        launch(1'b0, a, d);
      end
      default:
      begin
        step = 0;
        if (d == 16'h0030 || d == 16'h0050 || (d == 16'h0010 && a == 20'h05555))
          launch(1'b1, a, d);
      end
    endcase
  endtask
  // program only clears bits, so an unerased word keeps its zeros
  task automatic launch(input bit e, input [19:0] a, input [15:0] d);
    busy = 1;
    ers  = e;
    pd   = d;
    fork
    begin
      #(e ? ERASE_NS : PROG_NS);
      if (!e)
        mem[a] = mem[a] & d;
      else
        for (int k = 0; k < 1048576; k++)
          if (d == 16'h0010 || k[19:11] == a[19:11] || (d == 16'h0050 && k[19:15] == a[19:15]))
            mem[k] = 16'hffff;
      busy = 0;
    end
    join_none
  endtask
endmodule // nfc_flash_model

// ==== verification/tb_nfc_host.sv ====
/*
  self-checking bench for nfc_host against the flash model.
  assumes 2000-cycle timeouts, erase shortened and program lengthened, that still exceed the model busy times.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_nfc_host;
  logic        sys_clk = 0, rstn = 0, req_valid = 0;
  logic [2:0]  req_op = 3'h0;
  logic [19:0] req_addr = 20'h0, a;
  logic [15:0] req_data = 16'h0, d;
  wire         req_ready, done, fail, data_oe, chip_sel_n, out_gate_n, wr_strobe_n, dq_oe;
  wire [15:0]  rd_data, data_out, dq_out;
  wire [19:0]  addr_lines;
  int          fail_count = 0, num_checks = 0;
  // a released wire shows a pattern that flips, never the last value
  wire [15:0]  data_in = data_oe ? data_out : dq_oe ? dq_out : {8{sys_clk, ~sys_clk}};
  always #10 sys_clk = ~sys_clk;
  nfc_host #(.PROG_CYCLES(2000), .ERASE_CYCLES(2000)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .done(done), .fail(fail), .rd_data(rd_data), .addr_lines(addr_lines),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n));
  nfc_flash_model u_flash (.addr_lines(addr_lines), .dq_in(data_in), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .dq_out(dq_out), .dq_oe(dq_oe));
  // one request, then a bounded wait for its completion pulse
  task automatic op(input [2:0] o, input [19:0] ad, input [15:0] dt);
    int n = 0;
    @(posedge sys_clk);
    while (req_ready !== 1'b1) @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op    <= o;
    req_addr  <= ad;
    req_data  <= dt;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    do @(negedge sys_clk); while (done !== 1'b1 && ++n < 20000);
    `CHK(done, 1'b1)
    `CHK(fail, 1'b0)
  endtask
  // a program can only clear bits of what the word already holds
  function automatic logic [15:0] after_prog(input logic [15:0] old, input logic [15:0] nw);
    return old & nw;
  endfunction
  task automatic rd(input [19:0] ad, input [15:0] ex);
    op(3'h0, ad, 16'h0);
    `CHK(rd_data, ex)
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial
  begin
    #2000000;
    fail_count++;
    results();
  end
  initial
  begin
    void'($urandom(32'h0e1bd865));
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4)
    begin
      a = $urandom;
      d = $urandom;
      op(3'h4, 20'h05555, 16'h0);
      rd(a ^ 20'hfffff, 16'hffff);
      op(3'h1, a, d);
      rd(a, after_prog(16'hffff, d));
      op(3'h1, a ^ 20'hfffff, 16'h0000);
      rd(a ^ 20'hfffff, 16'h0000);
      op(3'h1, a, d ^ 16'h00ff);
      rd(a, after_prog(d, d ^ 16'h00ff));
      op(3'h1, a ^ 20'h00800, d);
      op(3'h1, a ^ 20'h08000, ~d);
      op(3'h2, a, 16'h0);
      rd(a, 16'hffff);
      rd(a ^ 20'h00800, d);
      op(3'h3, a ^ 20'h00800, 16'h0);
      rd(a ^ 20'h00800, 16'hffff);
      rd(a ^ 20'h08000, ~d);
    end
    results();
  end
endmodule // tb_nfc_host
